//--- verif/lcdc_host_model.sv
/*
  Host processor model: offers command and parameter bytes one at a time.
  Assumes the bench calls its tasks at a rising edge of core_clk.
*/
`timescale 1ns/1ps

module lcdc_host_model (
  input wire logic core_clk,
  input wire logic host_ready,
  output logic host_valid,
  output logic host_is_cmd,
  output logic [7:0] host_data
);
  // ************************************************************
  // byte offering
  // ************************************************************
  initial
  begin
    host_valid = 1'b0;
    host_is_cmd = 1'b0;
    host_data = 8'h00;
  end

  // hold the byte until ready is seen before a rising edge; cmd flag opens a command
  task automatic send(input logic c, input logic [7:0] d);
    logic r;
    host_valid <= 1'b1;
    host_is_cmd <= c;
    host_data <= d;
    r = 1'b0;
    while (!r)
    begin
      @(negedge core_clk);
      r = host_ready;
      @(posedge core_clk);
    end
  endtask

  // released bus shows a changed pattern, never the last byte
  task automatic idle;
    host_valid <= 1'b0;
    host_data <= ~host_data;
    @(posedge core_clk);
  endtask

  // bring-up order: blank, clear text layer, home cursor, shape, unblank
  task automatic init_clear(input int n);
    send(1'b1, 8'h58);
    send(1'b0, 8'h56);
    send(1'b1, 8'h46);
    send(1'b0, 8'h00);
    send(1'b0, 8'h00);
    send(1'b1, 8'h42);
    repeat (n) send(1'b0, 8'h20);
    send(1'b1, 8'h46);
    send(1'b0, 8'h00);
    send(1'b0, 8'h00);
    send(1'b1, 8'h5d);
    send(1'b0, 8'h04);
    send(1'b0, 8'h86);
    send(1'b1, 8'h59);
    idle();
  endtask
endmodule

//--- verif/test_lcd_cursor_display_cmds.sv
/*
  Self-checking bench for the command interpreter with a stalling memory sink.
  Assumes lcdc_pkg and lcdc_regs.svh are compiled and on the include path.
*/
`timescale 1ns/1ps
`include "lcdc_regs.svh"

module test_lcd_cursor_display_cmds;
  import lcdc_pkg::*;
  localparam logic [15:0] PITCH = 16'h0080;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic host_valid, host_ready, host_is_cmd, mem_wr_valid, display_on, cursor_style_bit;
  logic [7:0] host_data, rd_data, mem_wr_data;
  logic [7:0] rd_addr = 8'h00;
  logic mem_wr_ready = 1'b1;
  logic [15:0] mem_wr_addr, cursor_addr;
  logic [1:0] cursor_flash_select, first_block_attr, second_fourth_block_attr;
  logic [1:0] third_block_attr, cursor_dir;
  logic [3:0] cursor_width_field, cursor_height_field;
  logic [23:0] exp_q[$];
  logic [23:0] got_q[$];
  logic hold = 1'b0;
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;

  // ************************************************************
  // clock, parts and memory sink
  // ************************************************************
  always #2.5 core_clk = ~core_clk;

  lcdc_cmd_interp dut_u (.core_clk(core_clk), .rstn(rstn), .host_valid(host_valid),
    .host_ready(host_ready), .host_is_cmd(host_is_cmd), .host_data(host_data),
    .line_pitch(PITCH), .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready),
    .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data), .rd_addr(rd_addr),
    .rd_data(rd_data), .display_on(display_on), .cursor_flash_select(cursor_flash_select),
    .first_block_attr(first_block_attr), .second_fourth_block_attr(second_fourth_block_attr),
    .third_block_attr(third_block_attr), .cursor_width_field(cursor_width_field),
    .cursor_height_field(cursor_height_field), .cursor_style_bit(cursor_style_bit),
    .cursor_dir(cursor_dir), .cursor_addr(cursor_addr));

  lcdc_host_model hm_u (.core_clk(core_clk), .host_ready(host_ready),
    .host_valid(host_valid), .host_is_cmd(host_is_cmd), .host_data(host_data));

  // random stalls exercise the buffer; hold forces it full
  always @(posedge core_clk)
  begin
    if (mem_wr_valid === 1'b1 && mem_wr_ready === 1'b1)
      got_q.push_back({mem_wr_addr, mem_wr_data});
    mem_wr_ready <= hold ? 1'b0 : ($urandom % 3 != 0);
  end

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      results();
    end
  end

  // ************************************************************
  // helpers
  // ************************************************************
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    n_compared++;
    if (g !== e)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // read-back data is registered, so look one edge after the address
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    rd_addr <= a;
    @(posedge core_clk);
    #1 chk("rd_data", 24'(e), 24'(rd_data));
    @(posedge core_clk);
  endtask

  function automatic logic [15:0] step(input logic [15:0] a, input logic [1:0] d);
    case (d)
      `LCDC_DIR_RIGHT: step = a + 16'h0001;
      `LCDC_DIR_LEFT: step = a - 16'h0001;
      `LCDC_DIR_UP: step = a - PITCH;
      default: step = a + PITCH;
    endcase
  endfunction

  task automatic drain;
    int k;
    k = 0;
    while (mem_wr_valid !== 1'b0 && k < 200)
    begin
      @(posedge core_clk);
      k++;
    end
  endtask

  task automatic results;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    logic [7:0] c, v, ofs[7];
    logic [15:0] a;
    ofs = '{`LCDC_OFS_DISP_EN, `LCDC_OFS_ATTR, `LCDC_OFS_CSR_WIDTH, `LCDC_OFS_CSR_HEIGHT,
      `LCDC_OFS_CURSOR_DIR, `LCDC_OFS_CSR_LO, `LCDC_OFS_CSR_HI};
    void'($urandom(99));
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    foreach (ofs[i]) rd_chk(ofs[i], `LCDC_RST_BYTE);
    hm_u.init_clear(4);
    for (int i = 0; i < 4; i++) exp_q.push_back({16'(i), 8'h20});
    #1 chk("display_on", 24'h1, 24'(display_on));
    chk("width", 24'h4, 24'(cursor_width_field));
    chk("height style", 24'h16, 24'({cursor_style_bit, cursor_height_field}));
    chk("cursor", 24'h0, 24'(cursor_addr));
    @(posedge core_clk);
    rd_chk(`LCDC_OFS_CSR_HEIGHT, 8'h86);
    // random attributes under both switch codes
    repeat (4)
    begin
      c = $urandom_range(1) ? `LCDC_CMD_DISP_ON : `LCDC_CMD_DISP_OFF;
      v = 8'($urandom);
      hm_u.send(1'b1, c);
      hm_u.send(1'b0, v);
      hm_u.idle();
      #1 chk("display_on", 24'(c[0]), 24'(display_on));
      chk("attr", 24'(v), 24'({third_block_attr, second_fourth_block_attr,
        first_block_attr, cursor_flash_select}));
      @(posedge core_clk);
      rd_chk(`LCDC_OFS_ATTR, v);
    end
    // an interrupted cursor write, then a full one with a surplus byte
    hm_u.send(1'b1, `LCDC_CMD_CURSOR_WR);
    hm_u.send(1'b0, 8'h34);
    hm_u.send(1'b1, `LCDC_CMD_CURSOR_WR);
    hm_u.send(1'b0, 8'h01);
    hm_u.send(1'b0, 8'h10);
    hm_u.send(1'b0, 8'h77);
    // a foreign command and its parameter must touch nothing
    hm_u.send(1'b1, 8'h44);
    hm_u.send(1'b0, 8'h55);
    hm_u.idle();
    rd_chk(`LCDC_OFS_CSR_LO, 8'h01);
    rd_chk(`LCDC_OFS_CSR_HI, 8'h10);
    rd_chk(`LCDC_OFS_ATTR, v);
    a = 16'h1001;
    // every direction code, then a write burst stepping that way
    for (int k = 0; k < 4; k++)
    begin
      hm_u.send(1'b1, `LCDC_CMD_DIR_BASE | 8'(k));
      hm_u.send(1'b1, `LCDC_CMD_MEM_WR);
      repeat (1 + $urandom % 6)
      begin
        v = 8'($urandom);
        exp_q.push_back({a, v});
        a = step(a, 2'(k));
        hm_u.send(1'b0, v);
      end
      hm_u.idle();
      #1 chk("cursor", 24'(a), 24'(cursor_addr));
      chk("dir", 24'(k), 24'(cursor_dir));
      @(posedge core_clk);
      rd_chk(`LCDC_OFS_CURSOR_DIR, 8'(k));
    end
    // fill the buffer while memory refuses; the third byte must wait
    drain();
    hold <= 1'b1;
    repeat (2) @(posedge core_clk);
    for (int i = 0; i < 3; i++)
    begin
      v = 8'($urandom);
      exp_q.push_back({a, v});
      a = step(a, 2'h3);
      if (i == 2)
      begin
        #1 chk("host_ready", 24'h0, 24'(host_ready));
        @(posedge core_clk);
        hold <= 1'b0;
      end
      hm_u.send(1'b0, v);
    end
    hm_u.idle();
    drain();
    chk("writes", 24'(exp_q.size()), 24'(got_q.size()));
    foreach (exp_q[i]) if (i < got_q.size()) chk("mem write", exp_q[i], got_q[i]);
    // mid-run reset must bring every loaded register back to zero
    rstn <= 1'b0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    foreach (ofs[i]) rd_chk(ofs[i], `LCDC_RST_BYTE);
    rd_chk(8'h0b, 8'h00);
    rd_chk(8'hff, 8'h00);
    results();
  end
endmodule

//--- verilog/lcdc_cmd_interp.sv
/*
  Host command interpreter for display switch, cursor address, cursor shape,
  cursor direction and display memory write commands.
  Assumes host bytes synchronous to core_clk; the line pitch comes from the
  system setup logic elsewhere; display memory accepts writes by valid/ready.
*/
// Operation
// R1 - code 58h clears display enable bit 0, code 59h sets it
// R2 - first display switch parameter loads attribute; bits 1-0 pick cursor flash
// R3 - attribute bits 3-2, 5-4, 7-6 enable first, second/fourth, third blocks
// R4 - cursor write 46h: first parameter low byte, second high byte of address
// R5 - cursor shape 5Dh: first parameter bits 3-0 give width minus one
// R6 - second shape parameter: bits 3-0 height minus one, bit 7 block style
// R7 - direction command low two code bits stored as shift direction, 4Ch..4Fh
// R8 - memory write 42h stores each byte at cursor, then cursor steps
// R9 - host clears text layer with 20h via cursor write and memory write
// R10 - host turns display off during setup, back on afterwards
// R11 - command byte restarts parameter count; parameters map by position
`timescale 1ns/1ps
`include "lcdc_regs.svh"

module lcdc_cmd_interp
  import lcdc_pkg::*;
#(
  parameter int AW = 16,
  parameter int DW = 8
)(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic host_valid,
  output logic host_ready,
  input wire logic host_is_cmd,
  input wire logic [7:0] host_data,
  input wire logic [AW-1:0] line_pitch,
  output logic mem_wr_valid,
  input wire logic mem_wr_ready,
  output logic [AW-1:0] mem_wr_addr,
  output logic [DW-1:0] mem_wr_data,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data,
  output logic display_on,
  output logic [1:0] cursor_flash_select,
  output logic [1:0] first_block_attr,
  output logic [1:0] second_fourth_block_attr,
  output logic [1:0] third_block_attr,
  output logic [3:0] cursor_width_field,
  output logic [3:0] cursor_height_field,
  output logic cursor_style_bit,
  output logic [1:0] cursor_dir,
  output logic [AW-1:0] cursor_addr
);

  lcdc_state_t state_reg, state_next;
  logic [3:0] pidx_reg, pidx_next;
  logic [7:0] disp_en_reg, disp_en_next;
  logic [7:0] attr_reg, attr_next;
  logic [7:0] width_reg, width_next;
  logic [7:0] height_reg, height_next;
  logic [7:0] dir_reg, dir_next;
  logic [AW-1:0] cursor_reg, cursor_next;
  logic [7:0] rd_data_reg, rd_data_next;
  logic host_fire, cmd_fire, par_fire;

  lcdc_wr_if #(.AW(AW), .DW(DW)) wr_in ();
  lcdc_wr_if #(.AW(AW), .DW(DW)) wr_out ();

  // ************************************************************
  // cursor stepping
  // ************************************************************
  // up/down move by one line of the virtual screen; wraps at the top
  function automatic logic [AW-1:0] step_addr(input logic [AW-1:0] a,
                                               input lcdc_dir_t d,
                                               input logic [AW-1:0] pitch);
    logic [AW-1:0] r;
    r = a;
    unique case (d)
      `LCDC_DIR_RIGHT: r = a + {{(AW-1){1'b0}}, 1'b1};
      `LCDC_DIR_LEFT: r = a - {{(AW-1){1'b0}}, 1'b1};
      `LCDC_DIR_UP: r = a - pitch;
      `LCDC_DIR_DOWN: r = a + pitch;
    endcase
    return r;
  endfunction

  // ************************************************************
  // host handshake
  // ************************************************************
  // command bytes are never held off; memory data waits for buffer room
  assign host_ready = !(state_reg == ST_MWR && !host_is_cmd && !wr_in.ready);
  assign host_fire = host_valid && host_ready;
  assign cmd_fire = host_fire && host_is_cmd;
  assign par_fire = host_fire && !host_is_cmd;

  // write stream into the two-entry buffer
  assign wr_in.valid = par_fire && state_reg == ST_MWR; // R8
  assign wr_in.addr = cursor_reg; // R8
  assign wr_in.data = host_data;

  // ************************************************************
  // command and parameter decode
  // ************************************************************
  always_comb
  begin
    state_next = state_reg;
    pidx_next = pidx_reg;
    disp_en_next = disp_en_reg;
    attr_next = attr_reg;
    width_next = width_reg;
    height_next = height_reg;
    dir_next = dir_reg;
    cursor_next = cursor_reg;
    if (cmd_fire)
    begin
      pidx_next = 4'h0; // R11
      state_next = ST_IDLE;
      unique case (host_data)
        `LCDC_CMD_DISP_OFF:
        begin
          disp_en_next[`LCDC_DISP_EN_BIT] = 1'b0; // R1
          state_next = ST_DISP;
        end
        `LCDC_CMD_DISP_ON:
        begin
          disp_en_next[`LCDC_DISP_EN_BIT] = 1'b1; // R1
          state_next = ST_DISP;
        end
        `LCDC_CMD_CURSOR_WR: state_next = ST_CURSOR;
        `LCDC_CMD_FORM: state_next = ST_FORM;
        `LCDC_CMD_MEM_WR: state_next = ST_MWR;
        default: state_next = ST_IDLE; // other commands take no parameters; direction codes 4Ch..4Fh are decoded below
      endcase
      if (host_data[7:2] == 6'(`LCDC_CMD_DIR_BASE >> 2))
      begin
        dir_next = {6'h00, host_data[1:0]}; // R7
      end
    end
    else if (par_fire)
    begin
      // saturate so an overlong parameter run cannot alias to a field
      if (pidx_reg != 4'hf)
      begin
        pidx_next = pidx_reg + 4'h1; // R11
      end
      unique case (state_reg)
        ST_IDLE: ;
        ST_DISP: if (pidx_reg == 4'h0) attr_next = host_data; // R2 R3
        ST_CURSOR:
        begin
          if (pidx_reg == 4'h0) cursor_next[7:0] = host_data; // R4
          if (pidx_reg == 4'h1) cursor_next[AW-1:8] = host_data[AW-9:0]; // R4
        end
        ST_FORM:
        begin
          if (pidx_reg == 4'h0) width_next = {4'h0, host_data[3:0]}; // R5
          if (pidx_reg == 4'h1)
          begin
            height_next = {host_data[`LCDC_CSR_STYLE_BIT], 3'h0, host_data[3:0]}; // R6
          end
        end
        ST_MWR: cursor_next = step_addr(cursor_reg, dir_reg[1:0], line_pitch); // R8
      endcase
    end
  end

  // read-back of the register file, registered
  always_comb
  begin
    unique case (rd_addr)
      `LCDC_OFS_DISP_EN: rd_data_next = disp_en_reg;
      `LCDC_OFS_ATTR: rd_data_next = attr_reg;
      `LCDC_OFS_CSR_WIDTH: rd_data_next = width_reg;
      `LCDC_OFS_CSR_HEIGHT: rd_data_next = height_reg;
      `LCDC_OFS_CURSOR_DIR: rd_data_next = dir_reg;
      `LCDC_OFS_CSR_LO: rd_data_next = cursor_reg[7:0];
      `LCDC_OFS_CSR_HI: rd_data_next = cursor_reg[AW-1:8];
      default: rd_data_next = 8'h00;
    endcase
  end

  // register state
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      state_reg <= ST_IDLE;
      pidx_reg <= 4'h0;
      disp_en_reg <= `LCDC_RST_BYTE;
      attr_reg <= `LCDC_RST_BYTE;
      width_reg <= `LCDC_RST_BYTE;
      height_reg <= `LCDC_RST_BYTE;
      dir_reg <= `LCDC_RST_BYTE;
      cursor_reg <= '0;
      rd_data_reg <= 8'h00;
    end
    else
    begin
      state_reg <= state_next;
      pidx_reg <= pidx_next;
      disp_en_reg <= disp_en_next;
      attr_reg <= attr_next;
      width_reg <= width_next;
      height_reg <= height_next;
      dir_reg <= dir_next;
      cursor_reg <= cursor_next;
      rd_data_reg <= rd_data_next;
    end
  end

  // ************************************************************
  // buffer and outputs
  // ************************************************************
  lcdc_wbuf #(.AW(AW), .DW(DW)) u_wbuf (
    .core_clk(core_clk),
    .rstn(rstn),
    .in_if(wr_in),
    .out_if(wr_out)
  );

  assign mem_wr_valid = wr_out.valid;
  assign wr_out.ready = mem_wr_ready;
  assign mem_wr_addr = wr_out.addr;
  assign mem_wr_data = wr_out.data;
  assign rd_data = rd_data_reg;
  assign display_on = disp_en_reg[`LCDC_DISP_EN_BIT]; // R1
  assign cursor_flash_select = attr_reg[1:0]; // R2
  assign first_block_attr = attr_reg[3:2]; // R3
  assign second_fourth_block_attr = attr_reg[5:4]; // R3
  assign third_block_attr = attr_reg[7:6]; // R3
  assign cursor_width_field = width_reg[3:0];
  assign cursor_height_field = height_reg[3:0];
  assign cursor_style_bit = height_reg[`LCDC_CSR_STYLE_BIT];
  assign cursor_dir = dir_reg[1:0];
  assign cursor_addr = cursor_reg;

  // ************************************************************
  // assertions
  // ************************************************************
  a_disp_off_clear: assert property (@(posedge core_clk) disable iff (!rstn) // R1
    cmd_fire && host_data == `LCDC_CMD_DISP_OFF |=> !display_on [*1] ##0 state_reg == ST_DISP)
    else $error("display off command did not clear enable");
  a_disp_on_set: assert property (@(posedge core_clk) disable iff (!rstn) // R1
    cmd_fire && host_data == `LCDC_CMD_DISP_ON |=> display_on)
    else $error("display on command did not set enable");
  a_attr_load: assert property (@(posedge core_clk) disable iff (!rstn) // R2
    par_fire && state_reg == ST_DISP && pidx_reg == 4'h0
    |=> cursor_flash_select == $past(host_data[1:0]) && attr_reg == $past(host_data))
    else $error("attribute byte not stored");
  a_block_fields: assert property (@(posedge core_clk) disable iff (!rstn) // R3
    par_fire && state_reg == ST_DISP && pidx_reg == 4'h0
    |=> {third_block_attr, second_fourth_block_attr, first_block_attr} == $past(host_data[7:2]))
    else $error("screen block fields misplaced");
  a_csr_bytes: assert property (@(posedge core_clk) disable iff (!rstn) // R4
    cmd_fire && host_data == `LCDC_CMD_CURSOR_WR ##1 par_fire [*1] ##1 par_fire
    |=> cursor_addr == {$past(host_data[AW-9:0]), $past(host_data, 2)})
    else $error("cursor address bytes in wrong order");
  a_form_width: assert property (@(posedge core_clk) disable iff (!rstn) // R5
    par_fire && state_reg == ST_FORM && pidx_reg == 4'h0
    |=> cursor_width_field == $past(host_data[3:0]) && width_reg[7:4] == 4'h0)
    else $error("cursor width not stored");
  a_form_height: assert property (@(posedge core_clk) disable iff (!rstn) // R6
    par_fire && state_reg == ST_FORM && pidx_reg == 4'h1
    |=> cursor_height_field == $past(host_data[3:0]) && cursor_style_bit == $past(host_data[7]))
    else $error("cursor height or style not stored");
  a_dir_code: assert property (@(posedge core_clk) disable iff (!rstn) // R7
    cmd_fire && host_data[7:2] == 6'h13 |=> cursor_dir == $past(host_data[1:0]))
    else $error("shift direction not taken from code");
  a_mwr_step: assert property (@(posedge core_clk) disable iff (!rstn) // R8
    par_fire && state_reg == ST_MWR
    |-> wr_in.valid && wr_in.addr == cursor_reg
    ##1 cursor_reg == step_addr($past(cursor_reg), $past(dir_reg[1:0]), $past(line_pitch)))
    else $error("memory write or cursor step wrong");
  a_cmd_restart: assert property (@(posedge core_clk) disable iff (!rstn) // R11
    cmd_fire |=> pidx_reg == 4'h0 && (host_ready || state_reg == ST_MWR))
    else $error("command did not restart parameter count");

endmodule

//--- verilog/lcdc_pkg.sv
/*
  Types shared by the command interpreter and its write buffer.
  Assumes the constants header is available on the include path.
*/
package lcdc_pkg;

  // command being followed by parameter bytes
  typedef enum logic [2:0] {ST_IDLE, ST_DISP, ST_CURSOR, ST_FORM, ST_MWR} lcdc_state_t;

  typedef logic [1:0] lcdc_dir_t;

endpackage

//--- verilog/lcdc_regs.svh
/*
  Constants of the cursor and display command interpreter: command codes,
  register offsets, field positions, reset value and shift direction codes.
  Assumes inclusion by the interpreter module and by the bench.
*/
`ifndef LCDC_REGS_SVH
`define LCDC_REGS_SVH

// ************************************************************
// command codes
// ************************************************************
`define LCDC_CMD_DISP_OFF 8'h58
`define LCDC_CMD_DISP_ON 8'h59
`define LCDC_CMD_CURSOR_WR 8'h46
`define LCDC_CMD_FORM 8'h5d
`define LCDC_CMD_DIR_BASE 8'h4c
`define LCDC_CMD_MEM_WR 8'h42

// ************************************************************
// register offsets on the read-back port
// ************************************************************
`define LCDC_OFS_DISP_EN 8'h09
`define LCDC_OFS_ATTR 8'h0a
`define LCDC_OFS_CSR_WIDTH 8'h15
`define LCDC_OFS_CSR_HEIGHT 8'h16
`define LCDC_OFS_CURSOR_DIR 8'h17
`define LCDC_OFS_CSR_LO 8'h1c
`define LCDC_OFS_CSR_HI 8'h1d

// ************************************************************
// fields, reset value and direction codes
// ************************************************************
`define LCDC_DISP_EN_BIT 0
`define LCDC_CSR_STYLE_BIT 7
`define LCDC_RST_BYTE 8'h00
`define LCDC_DIR_RIGHT 2'h0
`define LCDC_DIR_LEFT 2'h1
`define LCDC_DIR_UP 2'h2
`define LCDC_DIR_DOWN 2'h3

`endif

//--- verilog/lcdc_wbuf.sv
/*
  Two-entry buffer for display memory writes, valid/ready on both sides.
  Assumes synchronous active-low reset on the shared core clock.
*/
`timescale 1ns/1ps

module lcdc_wbuf
  import lcdc_pkg::*;
#(
  parameter int AW = 16,
  parameter int DW = 8
)(
  input wire logic core_clk,
  input wire logic rstn,
  lcdc_wr_if.snk in_if,
  lcdc_wr_if.src out_if
);

  logic [AW+DW-1:0] mem_reg [2];
  logic [AW+DW-1:0] mem_next [2];
  logic wptr_reg, wptr_next, rptr_reg, rptr_next;
  logic [1:0] cnt_reg, cnt_next;
  logic push, pop;

  // ************************************************************
  // handshakes
  // ************************************************************
  // full refuses new words, so the source stalls instead of dropping
  assign in_if.ready = (cnt_reg != 2'h2);
  assign out_if.valid = (cnt_reg != 2'h0);
  assign out_if.addr = mem_reg[rptr_reg][AW+DW-1:DW];
  assign out_if.data = mem_reg[rptr_reg][DW-1:0];
  assign push = in_if.valid && in_if.ready;
  assign pop = out_if.valid && out_if.ready;

  // next pointers, count and storage
  always_comb
  begin
    mem_next = mem_reg;
    wptr_next = wptr_reg ^ push;
    rptr_next = rptr_reg ^ pop;
    cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
    if (push)
    begin
      mem_next[wptr_reg] = {in_if.addr, in_if.data};
    end
  end

  // storage needs no reset; pointers and count do
  always_ff @(posedge core_clk)
  begin
    mem_reg <= mem_next;
    if (!rstn)
    begin
      wptr_reg <= 1'b0;
      rptr_reg <= 1'b0;
      cnt_reg <= 2'h0;
    end
    else
    begin
      wptr_reg <= wptr_next;
      rptr_reg <= rptr_next;
      cnt_reg <= cnt_next;
    end
  end

endmodule

//--- verilog/lcdc_wr_if.sv
/*
  Display memory write stream between the interpreter and its buffer.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/1ps

interface lcdc_wr_if #(parameter int AW = 16, parameter int DW = 8);
  logic valid;
  logic ready;
  logic [AW-1:0] addr;
  logic [DW-1:0] data;

  modport src (output valid, output addr, output data, input ready);
  modport snk (input valid, input addr, input data, output ready);
endinterface
